// file: pvr_defines.svh
// How it works
// - register 0x11 bit 13 enables energy-detect power-down; resets to 0.
// - energy-present bit falls after 256ms without line energy, reads 1 with energy.
// - hardware reset forces energy-present to 1; software reset leaves it alone.
// - modes 000-011 fix 10H, 10F, 100H, 100F with auto-negotiation off.
// - modes 100 and 101 negotiate advertising 100 half only; 101 adds repeater.
// - mode 111 advertises everything; control bits 13 and 8 follow the negotiation.
// - mode sets default control bits 13,12,10,8 as 0000,0001,1000,1001,1100,1100.
// - half duplex senses carrier on transmit and receive; full and repeater on receive.
// - bits 4:0 of 0x12, default 00001b, give the management bus address.
// - override bit 15 clear lets the strap pin pick crossover; set uses bits 14,13.
// - with override, bit 14 enables auto crossover, else bit 13 picks the wiring.
// - manual bit 13 at 0 keeps transmit pair output; at 1 pair directions swap.
// - bit 10 pins the 10 Mbit receive PLL to the reference clock.
// - bit 4 of 0x1b reads the 10Base-T receive polarity, 1 when reversed.
// - flag bits 7..1 record energy, negotiation done, fault, link down, ack, pd, page.
// - mask bits 7-1 enable their sources when 1 (bit 0 has no source); bits 7-0 reset to 0.
// - bit 12 of 0x1f reads 1 only when auto-negotiation has finished.
// - bits 4-2 of 0x1f give 001 10H, 101 10F, 010 100H, 110 100F.
// - bits 11-5 of 0x1f reset to 0000010b and software writes that pattern.
`ifndef PVR_DEFINES_SVH
`define PVR_DEFINES_SVH
// register indices on the management bus
`define PVR_REG_MCS 5'h11
`define PVR_REG_SPM 5'h12
`define PVR_REG_XPC 5'h1b
`define PVR_REG_IRQF 5'h1d
`define PVR_REG_IRQM 5'h1e
`define PVR_REG_ANS 5'h1f
// field positions
`define PVR_EDPD_BIT 13
`define PVR_ENERGY_BIT 1
`define PVR_XO_OVR_BIT 15
`define PVR_XO_AUTO_BIT 14
`define PVR_XO_STATE_BIT 13
`define PVR_PLL_BIT 10
`define PVR_POL_BIT 4
`define PVR_AUTODONE_BIT 12
// reset values
`define PVR_MODE_RST 3'h7
`define PVR_ADDR_RST 5'h01
`define PVR_ANS_RSV_RST 7'h02
`define PVR_MASK_RST 8'h00
// timing
`define PVR_QUIET_MS 256
`define PVR_CLK_KHZ 125000
`define PVR_QUIET_CYCLES (`PVR_QUIET_MS * `PVR_CLK_KHZ)
`define PVR_PREAMBLE_BITS 6'h20
`define PVR_HDR_LAST 5'h0c
`define PVR_DATA_LAST 5'h0f
`endif

// file: pvr_pkg.sv
package pvr_pkg;
	// operating mode field
	typedef enum logic [2:0] {
		PVR_MODE_10H = 3'b000,
		PVR_MODE_10F = 3'b001,
		PVR_MODE_100H = 3'b010,
		PVR_MODE_100F = 3'b011,
		PVR_MODE_AN_HALF = 3'b100,
		PVR_MODE_REPEATER = 3'b101,
		PVR_MODE_RESERVED = 3'b110,
		PVR_MODE_ALL = 3'b111
	} pvr_mode_type;
	// management frame states
	typedef enum logic [1:0] {
		PVR_MS_IDLE = 2'b00,
		PVR_MS_HDR = 2'b01,
		PVR_MS_TA = 2'b10,
		PVR_MS_DATA = 2'b11
	} pvr_mdio_state_type;
endpackage

// file: pvr_energy_detect.sv
`timescale 1ns/10ps
`default_nettype none
`include "pvr_defines.svh"
module pvr_energy_detect #(
	parameter int unsigned QUIET_CYCLES = `PVR_QUIET_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// line energy pin
	input wire logic line_energy,
	// status
	output logic energy_present,
	output logic energy_rise
);
	localparam int CW = $clog2(QUIET_CYCLES + 1);
	logic energy_meta, energy_q;
	logic [CW-1:0] quiet_cnt;
	// two-flop synchroniser for the analog detector
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			energy_meta <= 1'b0;
			energy_q <= 1'b0;
		end else begin
			energy_meta <= line_energy;
			energy_q <= energy_meta;
		end
	end
	// quiet timer; only the hardware reset reaches this state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			energy_present <= 1'b1;
			energy_rise <= 1'b0;
			quiet_cnt <= '0;
		end else begin
			energy_rise <= energy_q & ~energy_present;
			if (energy_q) begin
				energy_present <= 1'b1;
				quiet_cnt <= '0;
			end else if (energy_present) begin
				if (quiet_cnt == CW'(QUIET_CYCLES - 1)) begin
					energy_present <= 1'b0;
					quiet_cnt <= '0;
				end else begin
					quiet_cnt <= quiet_cnt + CW'(1);
				end
			end
		end
	end
	// silence for the full window drops the status
	AST_ENERGY_FALL: assert property (@(posedge clk) disable iff (rst)
		energy_present && !energy_q && quiet_cnt == CW'(QUIET_CYCLES - 1)
		|=> !energy_present)
		else $error("energy status did not fall after quiet window");
endmodule
`default_nettype wire

// file: pvr_mdio_slave.sv
`timescale 1ns/10ps
`default_nettype none
`include "pvr_defines.svh"
module pvr_mdio_slave (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// management pins
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	// own address
	input wire logic [4:0] phy_addr,
	// register access
	output logic [4:0] reg_addr,
	output logic [15:0] wr_data,
	output logic wr_pulse,
	output logic rd_pulse,
	input wire logic [15:0] rd_data
);
	logic mdc_meta, mdc_q, mdc_prev, mdio_meta, mdio_q, rise, is_read;
	logic [5:0] ones;
	logic [4:0] cnt;
	logic [15:0] sh;
	pvr_pkg::pvr_mdio_state_type state;
	// pin synchronisers and clock edge detect
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mdc_meta <= 1'b0;
			mdc_q <= 1'b0;
			mdc_prev <= 1'b0;
			mdio_meta <= 1'b1;
			mdio_q <= 1'b1;
		end else begin
			mdc_meta <= mdc;
			mdc_q <= mdc_meta;
			mdc_prev <= mdc_q;
			mdio_meta <= mdio_in;
			mdio_q <= mdio_meta;
		end
	end
	assign rise = mdc_q & ~mdc_prev;
	// read strobe in the cycle the read word is captured
	assign rd_pulse = rise && state == pvr_pkg::PVR_MS_TA && cnt == 5'h00 && is_read;
	// frame sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= pvr_pkg::PVR_MS_IDLE;
			ones <= 6'h00;
			cnt <= 5'h00;
			sh <= 16'h0000;
			is_read <= 1'b0;
			reg_addr <= 5'h00;
			wr_data <= 16'h0000;
			wr_pulse <= 1'b0;
			mdio_out <= 1'b0;
			mdio_oe <= 1'b0;
		end else begin
			wr_pulse <= 1'b0;
			if (rise) begin
				unique case (state)
				pvr_pkg::PVR_MS_IDLE: begin
					if (mdio_q) begin
						ones <= (ones == `PVR_PREAMBLE_BITS) ? ones : ones + 6'h01;
					end else begin
						if (ones == `PVR_PREAMBLE_BITS) begin
							state <= pvr_pkg::PVR_MS_HDR;
						end
						ones <= 6'h00;
						cnt <= 5'h00;
					end
				end
				pvr_pkg::PVR_MS_HDR: begin
					sh <= {sh[14:0], mdio_q};
					cnt <= cnt + 5'h01;
					if (cnt == `PVR_HDR_LAST) begin
						cnt <= 5'h00;
						state <= pvr_pkg::PVR_MS_IDLE;
						if (sh[11] && (sh[10] ^ sh[9]) && sh[8:4] == phy_addr) begin
							state <= pvr_pkg::PVR_MS_TA;
							is_read <= sh[10];
							reg_addr <= {sh[3:0], mdio_q};
						end
					end
				end
				pvr_pkg::PVR_MS_TA: begin
					cnt <= cnt + 5'h01;
					if (cnt == 5'h00 && is_read) begin
						sh <= rd_data;
						mdio_oe <= 1'b1;
						mdio_out <= 1'b0;
					end else if (cnt != 5'h00) begin
						state <= pvr_pkg::PVR_MS_DATA;
						cnt <= 5'h00;
						mdio_out <= is_read & sh[15];
						sh <= {sh[14:0], 1'b0};
					end
				end
				pvr_pkg::PVR_MS_DATA: begin
					cnt <= cnt + 5'h01;
					sh <= {sh[14:0], mdio_q};
					if (is_read) begin
						mdio_out <= sh[15];
					end
					if (cnt == `PVR_DATA_LAST) begin
						state <= pvr_pkg::PVR_MS_IDLE;
						mdio_oe <= 1'b0;
						mdio_out <= 1'b0;
						wr_pulse <= ~is_read;
						wr_data <= {sh[14:0], mdio_q};
					end
				end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// file: pvr_vendor_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "pvr_defines.svh"
module pvr_vendor_regs #(
	parameter int unsigned QUIET_CYCLES = `PVR_QUIET_CYCLES
) (
	// clock and resets
	input wire logic clk,
	input wire logic rst,
	input wire logic soft_rst,
	// management pins
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	// line pins
	input wire logic line_energy,
	input wire logic crossover_strap_pin,
	// phy core status
	input wire logic autoneg_done,
	input wire logic link_up,
	input wire logic speed100,
	input wire logic full_duplex,
	input wire logic tenbase_polarity_reversed,
	input wire logic remote_fault,
	input wire logic partner_ack,
	input wire logic parallel_detect_fault,
	input wire logic page_received,
	input wire logic tx_active,
	input wire logic rx_active,
	// phy core controls
	output logic energy_detect_powerdown_en,
	output logic energy_present,
	output logic [4:0] mgmt_bus_address,
	output logic autoneg_en,
	output logic repeater_mode,
	output logic [3:0] ctrl_defaults,
	output logic [3:0] adv_abilities,
	output logic carrier_sense,
	output logic mdix_auto_en,
	output logic mdix_crossed,
	output logic rx_pll_ref_force,
	output logic [2:0] resolved_speed_duplex,
	output logic irq_out
);
	logic strap_meta, strap_q;
	logic [4:0] reg_addr;
	logic [15:0] wr_data, rd_data;
	logic wr_pulse, rd_pulse;
	pvr_pkg::pvr_mode_type mode;
	logic [7:0] spm_hi, mask, flags, events;
	logic xo_ovr, xo_auto, xo_state;
	logic [6:0] ans_rsv;
	logic an_done_q, energy_rise, rd_clr;
	logic [10:0] next_dec;
	////////////////////////////////////////////////////////////////////////
	// helpers
	// write or read strobe aimed at one register
	function automatic logic hit(input logic [4:0] a, input logic [4:0] r, input logic s);
		hit = s && (a == r);
	endfunction

	// mode to {autoneg, repeater, crs on tx, control bits, advertised bits}
	function automatic logic [10:0] mode_decode(input pvr_pkg::pvr_mode_type m,
		input logic spd, input logic fdx);
		unique case (m)
		pvr_pkg::PVR_MODE_10H,
		pvr_pkg::PVR_MODE_RESERVED: begin
			mode_decode = {3'h1, 4'h0, 4'h0};
		end
		pvr_pkg::PVR_MODE_10F: begin
			mode_decode = {3'h0, 4'h1, 4'h0};
		end
		pvr_pkg::PVR_MODE_100H: begin
			mode_decode = {3'h1, 4'h8, 4'h0};
		end
		pvr_pkg::PVR_MODE_100F: begin
			mode_decode = {3'h0, 4'h9, 4'h0};
		end
		pvr_pkg::PVR_MODE_AN_HALF: begin
			mode_decode = {3'h5, 4'hc, 4'h4};
		end
		pvr_pkg::PVR_MODE_REPEATER: begin
			mode_decode = {3'h6, 4'hc, 4'h4};
		end
		pvr_pkg::PVR_MODE_ALL: begin
			mode_decode = {2'h2, ~fdx, spd, 2'h2, fdx, 4'hf};
		end
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// submodules
	// serial management slave
	pvr_mdio_slave u_mdio (
		.clk(clk),
		.rst(rst),
		.mdc(mdc),
		.mdio_in(mdio_in),
		.mdio_out(mdio_out),
		.mdio_oe(mdio_oe),
		.phy_addr(mgmt_bus_address),
		.reg_addr(reg_addr),
		.wr_data(wr_data),
		.wr_pulse(wr_pulse),
		.rd_pulse(rd_pulse),
		.rd_data(rd_data)
	);

	// line energy timer
	pvr_energy_detect #(
		.QUIET_CYCLES(QUIET_CYCLES)
	) u_energy (
		.clk(clk),
		.rst(rst),
		.line_energy(line_energy),
		.energy_present(energy_present),
		.energy_rise(energy_rise)
	);

	////////////////////////////////////////////////////////////////////////
	// registers kept over software reset
	// mode and management address
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode <= pvr_pkg::pvr_mode_type'(`PVR_MODE_RST);
			mgmt_bus_address <= `PVR_ADDR_RST;
			spm_hi <= 8'h00;
		end else if (hit(reg_addr, `PVR_REG_SPM, wr_pulse)) begin
			spm_hi <= wr_data[15:8];
			mode <= pvr_pkg::pvr_mode_type'(wr_data[7:5]);
			mgmt_bus_address <= wr_data[4:0];
		end
	end

	// receive pll forcing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_pll_ref_force <= 1'b0;
		end else if (hit(reg_addr, `PVR_REG_XPC, wr_pulse)) begin
			rx_pll_ref_force <= wr_data[`PVR_PLL_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers returned to reset values by software reset
	// energy-detect power-down enable
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			energy_detect_powerdown_en <= 1'b0;
		end else if (soft_rst) begin
			energy_detect_powerdown_en <= 1'b0;
		end else if (hit(reg_addr, `PVR_REG_MCS, wr_pulse)) begin
			energy_detect_powerdown_en <= wr_data[`PVR_EDPD_BIT];
		end
	end

	// crossover control bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			xo_ovr <= 1'b0;
			xo_auto <= 1'b0;
			xo_state <= 1'b0;
		end else if (soft_rst) begin
			xo_ovr <= 1'b0;
			xo_auto <= 1'b0;
			xo_state <= 1'b0;
		end else if (hit(reg_addr, `PVR_REG_XPC, wr_pulse)) begin
			xo_ovr <= wr_data[`PVR_XO_OVR_BIT];
			xo_auto <= wr_data[`PVR_XO_AUTO_BIT];
			xo_state <= wr_data[`PVR_XO_STATE_BIT];
		end
	end

	// reserved pattern of the negotiation status register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ans_rsv <= `PVR_ANS_RSV_RST;
		end else if (soft_rst) begin
			ans_rsv <= `PVR_ANS_RSV_RST;
		end else if (hit(reg_addr, `PVR_REG_ANS, wr_pulse)) begin
			ans_rsv <= wr_data[11:5];
		end
	end

	// interrupt mask
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mask <= `PVR_MASK_RST;
		end else if (soft_rst) begin
			mask <= `PVR_MASK_RST;
		end else if (hit(reg_addr, `PVR_REG_IRQM, wr_pulse)) begin
			mask <= wr_data[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt sources
	// strap synchroniser and negotiation edge history
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_meta <= 1'b0;
			strap_q <= 1'b0;
			an_done_q <= 1'b0;
		end else begin
			strap_meta <= crossover_strap_pin;
			strap_q <= strap_meta;
			an_done_q <= autoneg_done;
		end
	end

	// event vector, level causes re-set the flag after a read
	assign events = {energy_rise, autoneg_done & ~an_done_q, remote_fault, ~link_up,
		partner_ack, parallel_detect_fault, page_received, 1'b0};
	assign rd_clr = hit(reg_addr, `PVR_REG_IRQF, rd_pulse);

	// latched flags, a new event wins over the read clear
	assign flags[0] = 1'b0;
	for (genvar i = 1; i < 8; i++) begin : g_flag
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				flags[i] <= 1'b0;
			end else if (soft_rst) begin
				flags[i] <= events[i];
			end else begin
				flags[i] <= events[i] | (flags[i] & ~rd_clr);
			end
		end
	end

	// interrupt output
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(flags & mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// decoded controls
	assign next_dec = mode_decode(mode, speed100, full_duplex);

	// mode driven operation
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			autoneg_en <= 1'b0;
			repeater_mode <= 1'b0;
			ctrl_defaults <= 4'h0;
			adv_abilities <= 4'h0;
			carrier_sense <= 1'b0;
		end else begin
			autoneg_en <= next_dec[10];
			repeater_mode <= next_dec[9];
			ctrl_defaults <= next_dec[7:4];
			adv_abilities <= next_dec[3:0];
			carrier_sense <= rx_active | (tx_active & next_dec[8]);
		end
	end

	// crossover selection and resolved speed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mdix_auto_en <= 1'b0;
			mdix_crossed <= 1'b0;
			resolved_speed_duplex <= 3'h0;
		end else begin
			mdix_auto_en <= xo_ovr ? xo_auto : strap_q;
			mdix_crossed <= xo_ovr & ~xo_auto & xo_state;
			resolved_speed_duplex <= {full_duplex, speed100, ~speed100};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux
	always_comb begin
		rd_data = 16'h0000;
		case (reg_addr)
		`PVR_REG_MCS: begin
			rd_data[`PVR_EDPD_BIT] = energy_detect_powerdown_en;
			rd_data[`PVR_ENERGY_BIT] = energy_present;
		end
		`PVR_REG_SPM: begin
			rd_data = {spm_hi, mode, mgmt_bus_address};
		end
		`PVR_REG_XPC: begin
			rd_data[`PVR_XO_OVR_BIT] = xo_ovr;
			rd_data[`PVR_XO_AUTO_BIT] = xo_auto;
			rd_data[`PVR_XO_STATE_BIT] = xo_state;
			rd_data[`PVR_PLL_BIT] = rx_pll_ref_force;
			rd_data[`PVR_POL_BIT] = tenbase_polarity_reversed;
		end
		`PVR_REG_IRQF: begin
			rd_data = {8'h00, flags};
		end
		`PVR_REG_IRQM: begin
			rd_data = {8'h00, mask};
		end
		`PVR_REG_ANS: begin
			rd_data[`PVR_AUTODONE_BIT] = autoneg_done & autoneg_en;
			rd_data[11:5] = ans_rsv;
			rd_data[4:2] = resolved_speed_duplex;
		end
		default: begin
			rd_data = 16'h0000;
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_EDPD_WRITE: assert property (
		hit(reg_addr, `PVR_REG_MCS, wr_pulse) && !soft_rst
		|=> energy_detect_powerdown_en == $past(wr_data[13]))
		else $error("power-down enable not written");
	AST_FIXED_NO_AN: assert property (
		!mode[2] |=> !autoneg_en)
		else $error("fixed mode left negotiation on");
	AST_REPEATER: assert property (
		mode == pvr_pkg::PVR_MODE_REPEATER
		|=> autoneg_en && repeater_mode && adv_abilities == 4'h4)
		else $error("repeater mode decode wrong");
	AST_ALL_CAPABLE: assert property (
		mode == pvr_pkg::PVR_MODE_ALL |=> adv_abilities == 4'hf
		&& ctrl_defaults[3] == $past(speed100) && ctrl_defaults[0] == $past(full_duplex))
		else $error("all capable mode decode wrong");
	AST_CTRL_100F: assert property (
		mode == pvr_pkg::PVR_MODE_100F |=> ctrl_defaults == 4'h9)
		else $error("control defaults wrong for 100 full");
	AST_CRS_FULL: assert property (
		mode == pvr_pkg::PVR_MODE_100F && tx_active && !rx_active |=> !carrier_sense)
		else $error("carrier sensed on transmit in full duplex");
	AST_CRS_HALF: assert property (
		mode == pvr_pkg::PVR_MODE_AN_HALF && tx_active |=> carrier_sense)
		else $error("carrier missed on transmit in half duplex");
	AST_ADDR_WRITE: assert property (
		hit(reg_addr, `PVR_REG_SPM, wr_pulse) |=> mgmt_bus_address == $past(wr_data[4:0]))
		else $error("management address not written");
	AST_STRAP: assert property (
		!xo_ovr |=> mdix_auto_en == $past(strap_q))
		else $error("strap not followed without override");
	AST_MANUAL_XO: assert property (
		xo_ovr && !xo_auto |=> mdix_crossed == $past(xo_state))
		else $error("manual crossover state not applied");
	AST_PLL_FORCE: assert property (
		hit(reg_addr, `PVR_REG_XPC, wr_pulse) |=> rx_pll_ref_force == $past(wr_data[10]))
		else $error("pll force bit not written");
	AST_FLAG_CLEAR: assert property (
		rd_clr && events == 8'h00 && !soft_rst |=> flags == 8'h00 ##1 flags == $past(events))
		else $error("flags not cleared by read");
	AST_IRQ_RAISE: assert property (
		|(flags & mask) |=> irq_out)
		else $error("masked-in flag did not raise interrupt");
	AST_AUTODONE: assert property (
		!mode[2] ##1 reg_addr == `PVR_REG_ANS |-> !rd_data[`PVR_AUTODONE_BIT])
		else $error("negotiation done shown while disabled");
	AST_SPEED: assert property (
		speed100 && full_duplex |=> resolved_speed_duplex == 3'h6)
		else $error("resolved speed code wrong");

	COV_WRITE: cover property (wr_pulse);
	COV_FLAG_READ: cover property (rd_clr && flags != 8'h00);
	COV_IRQ: cover property ($rose(irq_out));
	COV_AN_DONE: cover property (mode == pvr_pkg::PVR_MODE_ALL && autoneg_done);
endmodule
`default_nettype wire

// file: pvr_mdio_host.sv
`timescale 1ns/10ps
`default_nettype none
module pvr_mdio_host (
	// management pins
	output logic mdc,
	output logic drv,
	output logic dbit,
	input wire logic line,
	// clock
	input wire logic clk
);
	////////////////////////////////////////////////////////////////
	// idle: clock stands still, line released
	initial begin
		mdc = 1'b0;
		drv = 1'b0;
		dbit = 1'b1;
	end
	////////////////////////////////////////////////////////////////
	// one frame; the read turnaround and data are left to the device
	task automatic frame(input logic w, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] f;
		f = {32'hffff_ffff, 2'h1, w ? 2'h1 : 2'h2, pa, ra, 2'h2, wd};
		rd = 16'h0000;
		for (int i = 63; i >= 0; i--) begin
			@(posedge clk);
			#1;
			mdc = 1'b0;
			drv = w || (i > 17); // release before the turnaround on reads
			dbit = f[i];
			repeat (5) @(posedge clk);
			if (i < 16) rd[i] = line;
			#1;
			mdc = 1'b1;
			repeat (4) @(posedge clk);
		end
		#1;
		drv = 1'b0;
	endtask
endmodule
`default_nettype wire

// file: test_pvr_vendor_regs.sv
`timescale 1ns/10ps
`default_nettype none
module test_pvr_vendor_regs;
	logic clk, rst, soft_rst, line_energy, strap, an_done, link_up, spd, fdx, pol;
	logic rfault, pack, pdf, page, tx_act, rx_act;
	wire logic mdc, drv, dbit, mdio_out, mdio_oe, line;
	logic edpd, energy, an_en, rep, crs, mdix_auto, mdix_x, pll, irq;
	logic [4:0] addr, pa;
	logic [3:0] ctl, adv;
	logic [2:0] rsd;
	int err_total, tests_run;
	localparam logic [6:0][3:0] CTL = {4'hd, 4'hc, 4'hc, 4'h9, 4'h8, 4'h1, 4'h0};
	localparam logic [6:0][3:0] ADV = {4'hf, 4'h4, 4'h4, 4'h0, 4'h0, 4'h0, 4'h0};
	localparam logic [3:0][2:0] SPD = {3'h6, 3'h5, 3'h2, 3'h1};
	localparam logic [3:0][15:0] XW = {16'h2400, 16'hc000, 16'ha000, 16'h8000};
	// pull-up on the shared management line
	assign line = mdio_oe ? mdio_out : (drv ? dbit : 1'b1);
	pvr_mdio_host host (.mdc(mdc), .drv(drv), .dbit(dbit), .line(line), .clk(clk));
	pvr_vendor_regs #(.QUIET_CYCLES(40)) dut (.clk(clk), .rst(rst), .soft_rst(soft_rst),
		.mdc(mdc), .mdio_in(line), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
		.line_energy(line_energy), .crossover_strap_pin(strap), .autoneg_done(an_done),
		.link_up(link_up), .speed100(spd), .full_duplex(fdx),
		.tenbase_polarity_reversed(pol), .remote_fault(rfault), .partner_ack(pack),
		.parallel_detect_fault(pdf), .page_received(page), .tx_active(tx_act),
		.rx_active(rx_act), .energy_detect_powerdown_en(edpd), .energy_present(energy),
		.mgmt_bus_address(addr), .autoneg_en(an_en), .repeater_mode(rep),
		.ctrl_defaults(ctl), .adv_abilities(adv), .carrier_sense(crs),
		.mdix_auto_en(mdix_auto), .mdix_crossed(mdix_x), .rx_pll_ref_force(pll),
		.resolved_speed_duplex(rsd), .irq_out(irq));
	////////////////////////////////////////////////////////////////
	// clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	// compare, access and closing tasks
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			err_total++;
		end
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		logic [15:0] q;
		host.frame(1'b1, pa, ra, d, q);
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic rchk(input logic [4:0] ra, input logic [15:0] exp);
		logic [15:0] q;
		host.frame(1'b0, pa, ra, 16'h0000, q);
		chk("read data", q, exp);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic conclude;
		$display("mismatches %0d of %0d comparisons", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// watchdog
	initial begin
		#300000;
		err_total++;
		conclude();
	end
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{rst, line_energy, link_up, spd, fdx, tx_act} = 6'h3f;
		{soft_rst, strap, an_done, pol, rfault, pack, pdf, page, rx_act} = 9'h000;
		err_total = 0;
		tests_run = 0;
		pa = 5'h01;
		wt(5);
		rst = 1'b0;
		wt(5);
		chk("energy_present", 16'(energy), 16'h0001);
		chk("address", 16'(addr), 16'h0001);
		rchk(5'h12, 16'h00e1);
		rchk(5'h1e, 16'h0000);
		rchk(5'h1f, 16'h0058);
		rchk(5'h10, 16'h0000);
		for (int i = 0; i < 7; i++) begin
			wr(5'h12, {8'h00, (i == 6) ? 3'h7 : 3'(i), pa});
			chk("ctrl_defaults", 16'(ctl), 16'(CTL[i]));
			chk("adv_abilities", 16'(adv), 16'(ADV[i]));
			chk("autoneg_en", 16'(an_en), 16'(i > 3));
			chk("repeater_mode", 16'(rep), 16'(i == 5));
			if (i < 6) chk("carrier_sense", 16'(crs), 16'(!i[0]));
		end
		wr(5'h12, 16'h00e5);
		chk("address", 16'(addr), 16'h0005);
		rchk(5'h12, 16'hffff);
		pa = 5'h05;
		wr(5'h11, 16'h2000);
		chk("powerdown", 16'(edpd), 16'h0001);
		rchk(5'h11, 16'h2002);
		soft_rst = 1'b1;
		wt(1);
		soft_rst = 1'b0;
		line_energy = 1'b0;
		wt(20);
		chk("powerdown", 16'(edpd), 16'h0000);
		chk("energy_present", 16'(energy), 16'h0001);
		wt(40);
		chk("energy_present", 16'(energy), 16'h0000);
		soft_rst = 1'b1;
		wt(1);
		soft_rst = 1'b0;
		wt(2);
		chk("energy_present", 16'(energy), 16'h0000);
		line_energy = 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(5'h1b, XW[i]);
			chk("mdix_auto_en", 16'(mdix_auto), 16'(i == 2));
			chk("mdix_crossed", 16'(mdix_x), 16'(i == 1));
		end
		strap = 1'b1;
		pol = 1'b1;
		wt(5);
		chk("mdix_auto_en", 16'(mdix_auto), 16'h0001);
		chk("pll_force", 16'(pll), 16'h0001);
		rchk(5'h1b, 16'h2410);
		chk("irq_out", 16'(irq), 16'h0000);
		rchk(5'h1d, 16'h0080);
		rchk(5'h1d, 16'h0000);
		wr(5'h1e, 16'h0020);
		{pack, pdf, page} = 3'h7;
		wt(1);
		{pack, pdf, page} = 3'h0;
		wt(3);
		chk("irq_out", 16'(irq), 16'h0000);
		{rfault, an_done, link_up} = 3'h6;
		wt(1);
		rfault = 1'b0;
		wt(3);
		chk("irq_out", 16'(irq), 16'h0001);
		rchk(5'h1d, 16'h007e);
		wt(3);
		chk("irq_out", 16'(irq), 16'h0000);
		rchk(5'h1d, 16'h0010);
		rchk(5'h1f, 16'h1058);
		wr(5'h1f, 16'h0040);
		wr(5'h12, 16'h0005);
		rchk(5'h1f, 16'h0058);
		for (int i = 0; i < 4; i++) begin
			{fdx, spd} = 2'(i);
			wt(3);
			chk("speed_duplex", 16'(rsd), 16'(SPD[i]));
		end
		line_energy = 1'b0;
		wt(60);
		rst = 1'b1;
		wt(2);
		chk("energy_present", 16'(energy), 16'h0001);
		chk("address", 16'(addr), 16'h0001);
		conclude();
	end
endmodule
`default_nettype wire
